// ### rtl/ppcfg_defs.vh
// constants for the parallel and serial pin configuration block
`ifndef PPCFG_DEFS_VH
`define PPCFG_DEFS_VH

// register map, printed offset is not a multiple of four: index times four
`define PPCFG_CFG_INDEX 8'h09
`define PPCFG_CFG_ADDR 12'h024
`define PPCFG_I2C_CTRL_ADDR 12'h040
`define PPCFG_STATUS_ADDR 12'h044
`define PPCFG_PAR_FLAGS_ADDR 12'h048

// field positions in the shared configuration register
`define PPCFG_POS_BIT 7
`define PPCFG_LVAC_POL_BIT 5
`define PPCFG_DWAIT_POL_BIT 4
`define PPCFG_LVAC_BIT 3
`define PPCFG_DWAIT_BIT 2
`define PPCFG_WIDTH_HI 1
`define PPCFG_WIDTH_LO 0

// writable bits, reset value
`define PPCFG_CFG_WMASK 8'hB3
`define PPCFG_CFG_RESET 8'h00

// width field codes
`define PPCFG_W_NONE 2'h0
`define PPCFG_W_8 2'h1
`define PPCFG_W_16 2'h2
`define PPCFG_W_24 2'h3

`define PPCFG_ZERO8 8'h00
`define PPCFG_ONES8 8'hFF
`define PPCFG_I2C_PINS 8'h03
`define PPCFG_SCL_BIT 0
`define PPCFG_SDA_BIT 1

`endif

// ### rtl/ppcfg_decode.v
// combinational decode of width and serial position into pin ownership
`timescale 1ns/1ps
`include "ppcfg_defs.vh"

module ppcfg_decode (
   input wire [1:0] width_i,
   input wire pos_i,
   input wire i2c_en_i,
   output reg par_en_o,
   output reg [7:0] par_own0_o,
   output reg [7:0] par_own1_o,
   output reg [7:0] par_own3_o,
   output reg i2c_on_two_o,
   output reg [7:0] od_force1_o,
   output reg [7:0] od_force2_o
);

   // width decode and serial placement
   always @* begin
      par_en_o = (width_i != `PPCFG_W_NONE);
      par_own0_o = `PPCFG_ZERO8;
      par_own1_o = `PPCFG_ZERO8;
      par_own3_o = `PPCFG_ZERO8;
      case (width_i)
         `PPCFG_W_8: begin
            par_own0_o = `PPCFG_ONES8;
         end
         `PPCFG_W_16: begin
            par_own0_o = `PPCFG_ONES8;
            par_own1_o = `PPCFG_ONES8;
         end
         `PPCFG_W_24: begin
            par_own0_o = `PPCFG_ONES8;
            par_own1_o = `PPCFG_ONES8;
            par_own3_o = `PPCFG_ONES8;
         end
         default: begin
            par_own0_o = `PPCFG_ZERO8;
         end
      endcase
      // upper width bit claims port one, so serial moves to port two
      i2c_on_two_o = width_i[`PPCFG_WIDTH_HI] | pos_i;
      // open drain forced only once the serial function is enabled
      od_force1_o = (i2c_en_i && !i2c_on_two_o) ? `PPCFG_I2C_PINS : `PPCFG_ZERO8;
      od_force2_o = (i2c_en_i && i2c_on_two_o) ? `PPCFG_I2C_PINS : `PPCFG_ZERO8;
   end

endmodule

// ### rtl/ppcfg_top.v
// apb slave holding the shared parallel and serial pin configuration register
`timescale 1ns/1ps
`include "ppcfg_defs.vh"

module ppcfg_top (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire latch_vacant_i,
   input wire data_waiting_i,
   output reg par_en_o,
   output reg [1:0] par_width_o,
   output reg latch_vacant_polarity_o,
   output reg data_waiting_polarity_o,
   output reg [7:0] gpio_port_zero_par_o,
   output reg [7:0] gpio_port_one_par_o,
   output reg [7:0] gpio_port_three_par_o,
   output reg i2c_en_o,
   output reg i2c_on_two_o,
   output reg [7:0] gpio_port_one_od_o,
   output reg [7:0] gpio_port_two_od_o,
   output reg [7:0] gpio_port_zero_gpio_o,
   output reg [7:0] gpio_port_one_gpio_o,
   output reg [7:0] gpio_port_two_gpio_o,
   output reg [7:0] gpio_port_three_gpio_o
);

   reg [7:0] cfg_q;
   reg i2c_en_q;
   reg lvac_q;
   reg dwait_q;
   wire dec_par_en;
   wire [7:0] dec_own0;
   wire [7:0] dec_own1;
   wire [7:0] dec_own3;
   wire dec_on_two;
   wire [7:0] dec_od1;
   wire [7:0] dec_od2;
   wire access;
   wire wr;
   wire [7:0] cfg_view;
   reg [31:0] rdata_d;
   reg err_d;

   // byte lane zero write with strobe
   function [7:0] merge_byte;
      input [7:0] old;
      input [7:0] wdat;
      input [7:0] wmask;
      input lane;
      begin
         merge_byte = lane ? ((old & ~wmask) | (wdat & wmask)) : old;
      end
   endfunction

   ppcfg_decode u_dec (
      .width_i(cfg_q[`PPCFG_WIDTH_HI:`PPCFG_WIDTH_LO]),
      .pos_i(cfg_q[`PPCFG_POS_BIT]),
      .i2c_en_i(i2c_en_q),
      .par_en_o(dec_par_en),
      .par_own0_o(dec_own0),
      .par_own1_o(dec_own1),
      .par_own3_o(dec_own3),
      .i2c_on_two_o(dec_on_two),
      .od_force1_o(dec_od1),
      .od_force2_o(dec_od2)
   );

   // single wait-free access: answer on the first access cycle
   assign access = psel_i & penable_i;
   assign wr = access & pwrite_i;

   // flags read back with the stored read-write fields, reserved bit 6 zero
   assign cfg_view = {cfg_q[7:4], lvac_q, dwait_q, cfg_q[1:0]};

   // read mux and unmapped-address error
   always @* begin
      rdata_d = 32'h00000000;
      err_d = 1'b0;
      case (paddr_i)
         `PPCFG_CFG_ADDR: begin
            rdata_d = {24'h000000, cfg_view};
         end
         `PPCFG_I2C_CTRL_ADDR: begin
            rdata_d = {31'h00000000, i2c_en_q};
         end
         `PPCFG_STATUS_ADDR: begin
            rdata_d = {28'h0000000, i2c_en_q, dec_on_two, dec_par_en, 1'b0};
         end
         `PPCFG_PAR_FLAGS_ADDR: begin
            rdata_d = {30'h00000000, latch_vacant_i, data_waiting_i};
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   // software-visible registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= `PPCFG_CFG_RESET;
         i2c_en_q <= 1'b0;
      end else if (wr) begin
         if (paddr_i == `PPCFG_CFG_ADDR) begin
            // flags and reserved bit are not writable
            cfg_q <= merge_byte(cfg_q, pwdata_i[7:0], `PPCFG_CFG_WMASK, pstrb_i[0]);
         end
         if (paddr_i == `PPCFG_I2C_CTRL_ADDR && pstrb_i[0]) begin
            i2c_en_q <= pwdata_i[0];
         end
      end
   end

   // handshake flags only tracked while the parallel port runs
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvac_q <= 1'b0;
         dwait_q <= 1'b0;
      end else if (dec_par_en) begin
         lvac_q <= latch_vacant_i;
         dwait_q <= data_waiting_i;
      end else begin
         lvac_q <= 1'b0;
         dwait_q <= 1'b0;
      end
   end

   // apb answer registered so outputs come from flip-flops
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & err_d;
         prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rdata_d : 32'h00000000;
      end
   end

   // pin ownership outputs, one cycle after the register changes
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         par_en_o <= 1'b0;
         par_width_o <= `PPCFG_W_NONE;
         latch_vacant_polarity_o <= 1'b0;
         data_waiting_polarity_o <= 1'b0;
         gpio_port_zero_par_o <= `PPCFG_ZERO8;
         gpio_port_one_par_o <= `PPCFG_ZERO8;
         gpio_port_three_par_o <= `PPCFG_ZERO8;
         i2c_en_o <= 1'b0;
         i2c_on_two_o <= 1'b0;
         gpio_port_one_od_o <= `PPCFG_ZERO8;
         gpio_port_two_od_o <= `PPCFG_ZERO8;
         gpio_port_zero_gpio_o <= `PPCFG_ONES8;
         gpio_port_one_gpio_o <= `PPCFG_ONES8;
         gpio_port_two_gpio_o <= `PPCFG_ONES8;
         gpio_port_three_gpio_o <= `PPCFG_ONES8;
      end else begin
         par_en_o <= dec_par_en;
         par_width_o <= cfg_q[`PPCFG_WIDTH_HI:`PPCFG_WIDTH_LO];
         // polarities gated off when the parallel port is idle
         latch_vacant_polarity_o <= dec_par_en & cfg_q[`PPCFG_LVAC_POL_BIT];
         data_waiting_polarity_o <= dec_par_en & cfg_q[`PPCFG_DWAIT_POL_BIT];
         gpio_port_zero_par_o <= dec_own0;
         gpio_port_one_par_o <= dec_own1;
         gpio_port_three_par_o <= dec_own3;
         i2c_en_o <= i2c_en_q;
         i2c_on_two_o <= dec_on_two;
         gpio_port_one_od_o <= dec_od1;
         gpio_port_two_od_o <= dec_od2;
         // anything not claimed falls back to plain gpio
         gpio_port_zero_gpio_o <= ~dec_own0;
         gpio_port_one_gpio_o <= ~(dec_own1 | dec_od1);
         gpio_port_two_gpio_o <= ~dec_od2;
         gpio_port_three_gpio_o <= ~dec_own3;
      end
   end

endmodule

// ### tb/ppcfg_asserts.sv
// concurrent checks on the pin configuration block ports
`timescale 1ns/1ps
module ppcfg_asserts (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pready_o,
   input wire pslverr_o,
   input wire par_en_o,
   input wire [1:0] par_width_o,
   input wire latch_vacant_polarity_o,
   input wire [7:0] gpio_port_zero_par_o,
   input wire [7:0] gpio_port_one_par_o,
   input wire [7:0] gpio_port_three_par_o,
   input wire i2c_en_o,
   input wire i2c_on_two_o,
   input wire [7:0] gpio_port_one_od_o,
   input wire [7:0] gpio_port_two_od_o,
   input wire [7:0] gpio_port_zero_gpio_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("ready not a pulse after setup");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_par_en: assert property (par_en_o == |par_width_o)
      else $error("parallel enable wrong");
   a_port_zero: assert property (gpio_port_zero_par_o == {8{|par_width_o}})
      else $error("port zero ownership wrong");
   a_port_one: assert property (gpio_port_one_par_o == {8{par_width_o[1]}})
      else $error("port one ownership wrong");
   a_port_three: assert property (gpio_port_three_par_o == {8{&par_width_o}})
      else $error("port three ownership wrong");
   a_pol_gate: assert property (latch_vacant_polarity_o |-> par_en_o)
      else $error("polarity active without parallel port");
   a_wide_two: assert property (par_width_o[1] |-> i2c_on_two_o)
      else $error("wide port left serial on port one");
   a_od_two: assert property (gpio_port_two_od_o == ((i2c_en_o && i2c_on_two_o) ? 8'h03 : 8'h00))
      else $error("port two open drain wrong");
   a_od_off: assert property (!i2c_en_o |-> gpio_port_one_od_o == 8'h00)
      else $error("open drain without serial enable");
   a_gpio_zero: assert property (gpio_port_zero_gpio_o == ~gpio_port_zero_par_o)
      else $error("port zero gpio release wrong");
   c_wide: cover property (&par_width_o);
   c_od_one: cover property (gpio_port_one_od_o == 8'h03);
   c_err: cover property (pslverr_o);
endmodule

// ### tb/parallel_i2c_pin_config_tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/1ps
`include "ppcfg_defs.vh"
module parallel_i2c_pin_config_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic latch_vacant_i = 1'b0, data_waiting_i = 1'b0;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic [3:0] pstrb_i = 4'hF;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, par_en_o, latch_vacant_polarity_o, data_waiting_polarity_o;
   wire i2c_en_o, i2c_on_two_o;
   wire [1:0] par_width_o;
   wire [7:0] gpio_port_zero_par_o, gpio_port_one_par_o, gpio_port_three_par_o;
   wire [7:0] gpio_port_one_od_o, gpio_port_two_od_o, gpio_port_zero_gpio_o;
   wire [7:0] gpio_port_one_gpio_o, gpio_port_two_gpio_o, gpio_port_three_gpio_o;
   integer errors = 0, samples_checked = 0, cyc = 0;
   logic [31:0] rdat;
   logic rerr;
   ppcfg_top u_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .latch_vacant_i, .data_waiting_i,
      .par_en_o, .par_width_o, .latch_vacant_polarity_o, .data_waiting_polarity_o,
      .gpio_port_zero_par_o, .gpio_port_one_par_o, .gpio_port_three_par_o, .i2c_en_o,
      .i2c_on_two_o, .gpio_port_one_od_o, .gpio_port_two_od_o, .gpio_port_zero_gpio_o,
      .gpio_port_one_gpio_o, .gpio_port_two_gpio_o, .gpio_port_three_gpio_o);
   task close_out;
      begin
         $display("checked %0d mismatches %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         samples_checked++;
         if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge clk_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clk_i);
         penable_i <= 1'b1;
         do begin
            @(posedge clk_i);
         end while (pready_o !== 1'b1);
         rdat = prdata_o;
         rerr = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   // pin outputs land a cycle after the register, so wait before looking
   task pins(input logic [7:0] v, input logic en);
      logic [1:0] w;
      logic two;
      logic [7:0] o1, o2;
      begin
         w = v[1:0];
         two = v[7] | w[1];
         o1 = {6'h00, {2{en & ~two}}};
         o2 = {6'h00, {2{en & two}}};
         repeat (3) @(posedge clk_i);
         chk("p0", {8{|w}}, gpio_port_zero_par_o);
         chk("p1", {8{w[1]}}, gpio_port_one_par_o);
         chk("p3", {8{&w}}, gpio_port_three_par_o);
         chk("en", |w, par_en_o);
         chk("two", two, i2c_on_two_o);
         chk("pol", v[5] & (|w), latch_vacant_polarity_o);
         chk("pol2", v[4] & (|w), data_waiting_polarity_o);
         chk("wid", w, par_width_o);
         chk("ien", en, i2c_en_o);
         chk("g0", 8'(~{8{|w}}), gpio_port_zero_gpio_o);
         chk("g3", 8'(~{8{&w}}), gpio_port_three_gpio_o);
         chk("od1", o1, gpio_port_one_od_o);
         chk("od2", o2, gpio_port_two_od_o);
         chk("g1", 8'(~({8{w[1]}} | o1)), gpio_port_one_gpio_o);
         chk("g2", 8'(~o2), gpio_port_two_gpio_o);
      end
   endtask
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         close_out;
      end
   end
   initial begin
      logic [7:0] v;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, `PPCFG_CFG_ADDR, 32'h00000000);
      chk("cfg rst", 32'h00000000, rdat);
      chk("rst err", 1'b0, rerr);
      $display("test reset done");
      latch_vacant_i <= 1'b1;
      // every width and position, serial off then on; polarities swap with the pass
      // so a stuck polarity shows, read-only and reserved bits written as ones
      for (int j = 0; j < 2; j++) begin
         data_waiting_i <= j[0];
         xfer(1'b1, `PPCFG_I2C_CTRL_ADDR, j);
         for (int i = 0; i < 8; i++) begin
            v = {i[2], 1'b1, j[0], ~j[0], 2'h3, i[1:0]};
            xfer(1'b1, `PPCFG_CFG_ADDR, {24'h000000, v});
            pins(v, j[0]);
            xfer(1'b0, `PPCFG_CFG_ADDR, 32'h00000000);
            chk("cfg", {v[7], 1'b0, v[5:4], |v[1:0], j[0] & (|v[1:0]), v[1:0]}, rdat);
            xfer(1'b0, `PPCFG_STATUS_ADDR, 32'h00000000);
            chk("stat", {j[0], v[7] | v[1], |v[1:0], 1'b0}, rdat);
         end
      end
      xfer(1'b0, `PPCFG_PAR_FLAGS_ADDR, 32'h00000000);
      chk("flags", 32'h00000003, rdat);
      $display("test widths done");
      xfer(1'b1, 12'h100, 32'h000000FF);
      chk("err", 1'b1, rerr);
      xfer(1'b0, `PPCFG_CFG_ADDR, 32'h00000000);
      chk("cfg keep", 32'h000000AF, rdat);
      $display("test unmapped done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(1'b0, `PPCFG_CFG_ADDR, 32'h00000000);
      chk("cfg rst2", 32'h00000000, rdat);
      pins(8'h00, 1'b0);
      $display("test second reset done");
      close_out;
   end
endmodule
bind ppcfg_top ppcfg_asserts u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pready_o,
   .pslverr_o, .par_en_o, .par_width_o, .latch_vacant_polarity_o, .gpio_port_zero_par_o,
   .gpio_port_one_par_o, .gpio_port_three_par_o, .i2c_en_o, .i2c_on_two_o,
   .gpio_port_one_od_o, .gpio_port_two_od_o, .gpio_port_zero_gpio_o);
